// ===== hdl/pief_consts.svh
// Constants of the primary interrupt enable and flag bank.
// Assumes inclusion by bare name from the package and the top module.
`ifndef PIEF_CONSTS_SVH
`define PIEF_CONSTS_SVH

// Register bus geometry.
`define PIEF_ADDR_W        3
`define PIEF_DATA_W        8
`define PIEF_NUM_SRC       11

// Register offsets on the plain register port.
`define PIEF_ADDR_CTRL_A   3'h0
`define PIEF_ADDR_CTRL_B   3'h1
`define PIEF_ADDR_CTRL_C   3'h2
`define PIEF_ADDR_EVT_STAT 3'h3
`define PIEF_ADDR_EVT_MASK 3'h4

// Reset value of every register.
`define PIEF_REG_RESET     8'h00

// First control register fields; bit 7 is unimplemented.
`define PIEF_A_GIE         0
`define PIEF_A_PA_EN       1
`define PIEF_A_CMP_EN      2
`define PIEF_A_GA_EN       3
`define PIEF_A_PA_FLAG     4
`define PIEF_A_CMP_FLAG    5
`define PIEF_A_GA_FLAG     6

// Second control register fields.
`define PIEF_B_GB_EN       0
`define PIEF_B_GC_EN       1
`define PIEF_B_CONV_EN     2
`define PIEF_B_TA_EN       3
`define PIEF_B_GB_FLAG     4
`define PIEF_B_GC_FLAG     5
`define PIEF_B_CONV_FLAG   6
`define PIEF_B_TA_FLAG     7

// Third control register fields.
`define PIEF_C_TB_EN       0
`define PIEF_C_PB_EN       1
`define PIEF_C_SM_EN       2
`define PIEF_C_SP_EN       3
`define PIEF_C_TB_FLAG     4
`define PIEF_C_PB_FLAG     5
`define PIEF_C_SM_FLAG     6
`define PIEF_C_SP_FLAG     7

// Event status and mask fields.
`define PIEF_EVT_REQ       0
`define PIEF_EVT_OVR       1

`endif

// ===== hdl/pief_pkg.sv
// Types shared by the primary interrupt enable and flag bank.
// Assumes the constants header sits beside this file.
`include "pief_consts.svh"

package pief_pkg;

  // One bit per interrupt source, one vector per field.
  typedef struct packed {
    logic serial_port;
    logic serial_module;
    logic ext_pin_b;
    logic tick_b;
    logic tick_a;
    logic converter;
    logic shared_group_c;
    logic shared_group_b;
    logic shared_group_a;
    logic comparator;
    logic ext_pin_a;
  } pief_src_t;

  // Request pulses from on-chip sources on the system clock.
  typedef struct packed {
    logic serial_port;
    logic serial_module;
    logic tick_b;
    logic tick_a;
    logic converter;
    logic shared_group_c;
    logic shared_group_b;
    logic shared_group_a;
    logic comparator;
  } pief_int_src_t;

  // One register port request.
  typedef struct packed {
    logic [`PIEF_ADDR_W-1:0] addr;
    logic [`PIEF_DATA_W-1:0] wdata;
    logic                    wr;
    logic                    rd;
  } pief_bus_req_t;

endpackage

// ===== hdl/pief_pin_sync.sv
// Three-stage synchroniser with rising-edge detection for one pin.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps

module pief_pin_sync
(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Pin and detected edge.
  input  wire logic pin_in,
  output logic      rise_out
);

  logic stage1;  // First stage, read only by stage2.
  logic stage2;  // Second stage.
  logic stage3;  // Third stage.
  logic stable;  // Last level on which stages two and three agreed.

  // Shift the pin through the three stages.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end
    else
    begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a level once two stages agree and pulse on a new high.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stable   <= 1'b0;
      rise_out <= 1'b0;
    end
    else
    begin
      if (stage2 == stage3)
      begin
        stable <= stage3;
      end
      rise_out <= (stage2 == stage3) && stage3 && !stable;
    end
  end

endmodule

// ===== hdl/pief_flag_bit.sv
// One request flag: set by its source, read and written by software.
// Assumes set and write arrive on the same clock.
`timescale 1ns/1ps

module pief_flag_bit
(
  // Clock and reset.
  input  wire logic clk_in,
  input  wire logic nrst_in,
  // Source set and software write.
  input  wire logic set_in,
  input  wire logic wr_in,
  input  wire logic wval_in,
  // Flag state.
  output logic      q_out
);

  // A source request wins over a software write in the same cycle.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      q_out <= 1'b0;
    end
    else if (set_in)
    begin
      q_out <= 1'b1;
    end
    else if (wr_in)
    begin
      q_out <= wval_in;
    end
  end

endmodule

// ===== hdl/pief_top.sv
// Primary interrupt enable and request flag bank with register port.
// Assumes on-chip sources give one-cycle pulses on clk_in, the pins are
// asynchronous, and the core services requests by clearing flags.
//
// Contract
// - Comparator flag bit 5, enable bit 2
// - Pin A flag bit 4, enable bit 1
// - Group A flag bit 6, enable bit 3
// - Tick A flag bit 7, enable bit 3
// - Converter flag bit 6, enable bit 2
// - Group C flag bit 5, enable bit 1
// - Group B flag bit 4, enable bit 0
// - Serial port flag bit 7, enable bit 3
// - Serial module flag bit 6, enable bit 2
// - Pin B flag bit 5, enable bit 1
// - Tick B flag bit 4, enable bit 0
// - Flags show pending requests, software read/write
// - Enable one permits, zero blocks, read/write
// - Each group shares one vector
`timescale 1ns/1ps
`include "pief_consts.svh"

module pief_top
  import pief_pkg::*;
(
  // Clock and reset.
  input  wire logic          clk_in,
  input  wire logic          nrst_in,
  // Register port.
  input  wire pief_bus_req_t bus_in,
  output logic [7:0]         rd_data_out,
  // Interrupt sources.
  input  wire logic          ext_pin_a_in,
  input  wire logic          ext_pin_b_in,
  input  wire pief_int_src_t src_pulse_in,
  // Requests toward the core and system interrupt.
  output pief_src_t          vector_req_out,
  output logic               core_irq_out,
  output logic               sys_irq_out
);

  logic                     pin_a_rise;        // Edge seen on pin A.
  logic                     pin_b_rise;        // Edge seen on pin B.
  pief_src_t                src_set;           // Set pulse per source.
  pief_src_t                flag;              // Request flags.
  pief_src_t                flag_wr;           // Software write per flag.
  pief_src_t                flag_wval;         // Value written per flag.
  pief_src_t                enable;            // Per-source enables.
  logic                     global_irq_enable; // Global enable.
  logic [7:0]               evt_status;        // Sticky event bits.
  logic [7:0]               evt_mask;          // Event mask.
  logic [7:0]               evt_set;           // Event set pulses.
  logic [7:0]               next_rd_data;      // Read word to register.
  pief_src_t                next_vector_req;   // Gated requests.
  logic                     wr_a;              // Write to first register.
  logic                     wr_b;              // Write to second register.
  logic                     wr_c;              // Write to third register.

  // Synchronise both external pins and detect their rising edges.
  pief_pin_sync u_sync_a
  (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pin_in   (ext_pin_a_in),
    .rise_out (pin_a_rise)
  );

  pief_pin_sync u_sync_b
  (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .pin_in   (ext_pin_b_in),
    .rise_out (pin_b_rise)
  );

  // Gather all set pulses into one source vector.
  always_comb
  begin
    src_set                = '0;
    src_set.ext_pin_a      = pin_a_rise;
    src_set.ext_pin_b      = pin_b_rise;
    src_set.comparator     = src_pulse_in.comparator;
    src_set.shared_group_a = src_pulse_in.shared_group_a;
    src_set.shared_group_b = src_pulse_in.shared_group_b;
    src_set.shared_group_c = src_pulse_in.shared_group_c;
    src_set.converter      = src_pulse_in.converter;
    src_set.tick_a         = src_pulse_in.tick_a;
    src_set.tick_b         = src_pulse_in.tick_b;
    src_set.serial_module  = src_pulse_in.serial_module;
    src_set.serial_port    = src_pulse_in.serial_port;
  end

  // Decode writes to the three control registers.
  assign wr_a = bus_in.wr && (bus_in.addr == `PIEF_ADDR_CTRL_A);
  assign wr_b = bus_in.wr && (bus_in.addr == `PIEF_ADDR_CTRL_B);
  assign wr_c = bus_in.wr && (bus_in.addr == `PIEF_ADDR_CTRL_C);

  // Route each written data bit to its flag.
  always_comb
  begin
    flag_wr                  = '0;
    flag_wval                = '0;
    flag_wr.comparator       = wr_a;
    flag_wval.comparator     = bus_in.wdata[`PIEF_A_CMP_FLAG];
    flag_wr.ext_pin_a        = wr_a;
    flag_wval.ext_pin_a      = bus_in.wdata[`PIEF_A_PA_FLAG];
    flag_wr.shared_group_a   = wr_a;
    flag_wval.shared_group_a = bus_in.wdata[`PIEF_A_GA_FLAG];
    flag_wr.tick_a           = wr_b;
    flag_wval.tick_a         = bus_in.wdata[`PIEF_B_TA_FLAG];
    flag_wr.converter        = wr_b;
    flag_wval.converter      = bus_in.wdata[`PIEF_B_CONV_FLAG];
    flag_wr.shared_group_c   = wr_b;
    flag_wval.shared_group_c = bus_in.wdata[`PIEF_B_GC_FLAG];
    flag_wr.shared_group_b   = wr_b;
    flag_wval.shared_group_b = bus_in.wdata[`PIEF_B_GB_FLAG];
    flag_wr.serial_port      = wr_c;
    flag_wval.serial_port    = bus_in.wdata[`PIEF_C_SP_FLAG];
    flag_wr.serial_module    = wr_c;
    flag_wval.serial_module  = bus_in.wdata[`PIEF_C_SM_FLAG];
    flag_wr.ext_pin_b        = wr_c;
    flag_wval.ext_pin_b      = bus_in.wdata[`PIEF_C_PB_FLAG];
    flag_wr.tick_b           = wr_c;
    flag_wval.tick_b         = bus_in.wdata[`PIEF_C_TB_FLAG];
  end

  // One flag cell per source; only a software write clears a flag.
  for (genvar i = 0; i < `PIEF_NUM_SRC; i++)
  begin : g_flag
    pief_flag_bit u_flag
    (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .set_in  (src_set[i]),
      .wr_in   (flag_wr[i]),
      .wval_in (flag_wval[i]),
      .q_out   (flag[i])
    );
  end

  // Enable bits and the global enable, written by software.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      enable            <= '0;
      global_irq_enable <= 1'b0;
    end
    else
    begin
      if (wr_a)
      begin
        global_irq_enable     <= bus_in.wdata[`PIEF_A_GIE];
        enable.ext_pin_a      <= bus_in.wdata[`PIEF_A_PA_EN];
        enable.comparator     <= bus_in.wdata[`PIEF_A_CMP_EN];
        enable.shared_group_a <= bus_in.wdata[`PIEF_A_GA_EN];
      end
      if (wr_b)
      begin
        enable.shared_group_b <= bus_in.wdata[`PIEF_B_GB_EN];
        enable.shared_group_c <= bus_in.wdata[`PIEF_B_GC_EN];
        enable.converter      <= bus_in.wdata[`PIEF_B_CONV_EN];
        enable.tick_a         <= bus_in.wdata[`PIEF_B_TA_EN];
      end
      if (wr_c)
      begin
        enable.tick_b        <= bus_in.wdata[`PIEF_C_TB_EN];
        enable.ext_pin_b     <= bus_in.wdata[`PIEF_C_PB_EN];
        enable.serial_module <= bus_in.wdata[`PIEF_C_SM_EN];
        enable.serial_port   <= bus_in.wdata[`PIEF_C_SP_EN];
      end
    end
  end

  // A vector requests only with its flag, its enable and the global enable.
  assign next_vector_req = global_irq_enable ? (flag & enable) : '0;

  // Register the vector requests; each group drives one vector.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      vector_req_out <= '0;
      core_irq_out   <= 1'b0;
    end
    else
    begin
      vector_req_out <= next_vector_req;
      core_irq_out   <= |next_vector_req;
    end
  end

  // Events: a new core request, and a source firing on a pending flag.
  always_comb
  begin
    evt_set                = '0;
    evt_set[`PIEF_EVT_REQ] = (|next_vector_req) && !core_irq_out;
    evt_set[`PIEF_EVT_OVR] = |(src_set & flag);
  end

  // Sticky status, cleared by writing one; a new event wins the clear.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      evt_status <= `PIEF_REG_RESET;
    end
    else if (bus_in.wr && (bus_in.addr == `PIEF_ADDR_EVT_STAT))
    begin
      evt_status <= (evt_status & ~bus_in.wdata) | evt_set;
    end
    else
    begin
      evt_status <= evt_status | evt_set;
    end
  end

  // Event mask register, fully writable.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      evt_mask <= `PIEF_REG_RESET;
    end
    else if (bus_in.wr && (bus_in.addr == `PIEF_ADDR_EVT_MASK))
    begin
      evt_mask <= bus_in.wdata;
    end
  end

  // Level interrupt while any unmasked status bit is set.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      sys_irq_out <= 1'b0;
    end
    else
    begin
      sys_irq_out <= |(evt_status & evt_mask);
    end
  end

  // Read multiplexer; unmapped offsets read zero.
  always_comb
  begin
    next_rd_data = 8'h00;
    case (bus_in.addr)
      `PIEF_ADDR_CTRL_A:
      begin
        next_rd_data = {1'b0, flag.shared_group_a, flag.comparator,
                        flag.ext_pin_a, enable.shared_group_a,
                        enable.comparator, enable.ext_pin_a,
                        global_irq_enable};
      end
      `PIEF_ADDR_CTRL_B:
      begin
        next_rd_data = {flag.tick_a, flag.converter, flag.shared_group_c,
                        flag.shared_group_b, enable.tick_a, enable.converter,
                        enable.shared_group_c, enable.shared_group_b};
      end
      `PIEF_ADDR_CTRL_C:
      begin
        next_rd_data = {flag.serial_port, flag.serial_module,
                        flag.ext_pin_b, flag.tick_b, enable.serial_port,
                        enable.serial_module, enable.ext_pin_b,
                        enable.tick_b};
      end
      `PIEF_ADDR_EVT_STAT:
      begin
        next_rd_data = evt_status;
      end
      `PIEF_ADDR_EVT_MASK:
      begin
        next_rd_data = evt_mask;
      end
      default:
      begin
        next_rd_data = 8'h00;
      end
    endcase
  end

  // Read data stands for the one cycle after the read strobe.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rd_data_out <= 8'h00;
    end
    else
    begin
      rd_data_out <= bus_in.rd ? next_rd_data : 8'h00;
    end
  end

  // Checks on the register layout, flags and request gating.
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  AST_CTRL_A_LAYOUT: assert property (
    bus_in.rd && bus_in.addr == `PIEF_ADDR_CTRL_A |=>
      rd_data_out[`PIEF_A_CMP_FLAG] == $past(flag.comparator) &&
      rd_data_out[`PIEF_A_PA_FLAG] == $past(flag.ext_pin_a) &&
      rd_data_out[`PIEF_A_GA_EN] == $past(enable.shared_group_a) &&
      rd_data_out[7] == 1'b0)
    else $error("First control register read mismatch.");

  AST_CTRL_B_LAYOUT: assert property (
    bus_in.rd && bus_in.addr == `PIEF_ADDR_CTRL_B |=>
      rd_data_out[`PIEF_B_TA_FLAG] == $past(flag.tick_a) &&
      rd_data_out[`PIEF_B_GC_FLAG] == $past(flag.shared_group_c) &&
      rd_data_out[`PIEF_B_GB_EN] == $past(enable.shared_group_b))
    else $error("Second control register read mismatch.");

  AST_CTRL_C_LAYOUT: assert property (
    bus_in.rd && bus_in.addr == `PIEF_ADDR_CTRL_C |=>
      rd_data_out[`PIEF_C_SP_FLAG] == $past(flag.serial_port) &&
      rd_data_out[`PIEF_C_PB_FLAG] == $past(flag.ext_pin_b) &&
      rd_data_out[`PIEF_C_TB_EN] == $past(enable.tick_b))
    else $error("Third control register read mismatch.");

  AST_SOURCE_SETS_FLAG: assert property (
    src_pulse_in.converter |=> flag.converter ##1 vector_req_out.converter ||
      !$past(enable.converter && global_irq_enable))
    else $error("Converter pulse did not raise its flag.");

  AST_SET_WINS_CLEAR: assert property (
    src_pulse_in.comparator && wr_a && !bus_in.wdata[`PIEF_A_CMP_FLAG] |=>
      flag.comparator)
    else $error("Clear beat a simultaneous comparator request.");

  AST_NO_AUTO_CLEAR: assert property (
    flag.serial_port && !wr_c |=> flag.serial_port)
    else $error("Serial port flag cleared without a write.");

  AST_ENABLE_WRITE: assert property (
    wr_b |=> enable.converter == $past(bus_in.wdata[`PIEF_B_CONV_EN]))
    else $error("Converter enable did not take the written value.");

  AST_CORE_GATING: assert property (
    ##1 core_irq_out == $past(global_irq_enable && |(flag & enable)))
    else $error("Core request does not follow flag, enable and global.");

  AST_GROUP_VECTOR: assert property (
    flag.shared_group_b && enable.shared_group_b && global_irq_enable &&
      !wr_b && !wr_a |=> ##1 vector_req_out.shared_group_b)
    else $error("Group vector missing for a pending enabled group.");

  AST_READ_ONE_CYCLE: assert property (
    !bus_in.rd |=> rd_data_out == 8'h00)
    else $error("Read data present without a read.");

  COV_PIN_A_REQUEST: cover property (
    pin_a_rise ##1 flag.ext_pin_a ##[1:3] core_irq_out);
  COV_SET_AND_CLEAR: cover property (
    src_pulse_in.tick_a && wr_b);
  COV_SYS_IRQ: cover property (
    $rose(sys_irq_out));

endmodule

// ===== dv/pief_src_model.sv
// Model of the interrupt sources that stand around the flag bank.
// Assumes the bench raises one fire bit for one cycle per event.
`timescale 1ns/1ps

module pief_src_model
  import pief_pkg::*;
(
  // Clock and reset.
  input  wire logic      clk_in,
  input  wire logic      nrst_in,
  // Event requests from the bench.
  input  wire pief_src_t fire_in,
  // Source pulses and pin levels toward the block.
  output pief_int_src_t  pulse_out,
  output logic           pin_a_out,
  output logic           pin_b_out
);
  logic [3:0] hold_a;  // Cycles left with pin A high.
  logic [3:0] hold_b;  // Cycles left with pin B high.

  // On-chip sources give a single-cycle pulse on the system clock.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pulse_out <= '0;
    else
      pulse_out <= {fire_in.serial_port, fire_in.serial_module, fire_in.tick_b,
                    fire_in.tick_a, fire_in.converter, fire_in.shared_group_c,
                    fire_in.shared_group_b, fire_in.shared_group_a, fire_in.comparator};
  end

  // Pins stay high long enough for the synchroniser, then fall back to idle.
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      hold_a <= 4'h0;
      hold_b <= 4'h0;
    end
    else
    begin
      hold_a <= fire_in.ext_pin_a ? 4'h6 : (hold_a != 4'h0 ? hold_a - 4'h1 : 4'h0);
      hold_b <= fire_in.ext_pin_b ? 4'h6 : (hold_b != 4'h0 ? hold_b - 4'h1 : 4'h0);
    end
  end

  assign pin_a_out = (hold_a != 4'h0);
  assign pin_b_out = (hold_b != 4'h0);
endmodule

// ===== dv/pief_top_tb.sv
// Self-checking bench for the interrupt enable and flag bank.
// Assumes the register offsets and event bits of the constants header.
`timescale 1ns/1ps
`include "pief_consts.svh"

module pief_top_tb
  import pief_pkg::*;
;
  logic          clk_in;       // System clock.
  logic          nrst_in;      // Reset, active low.
  pief_bus_req_t bus;          // Register port request.
  logic [7:0]    rd_data_out;  // Read data.
  pief_src_t     fire;         // Event requests to the source model.
  pief_int_src_t pulse;        // On-chip source pulses.
  logic          pin_a;        // External pin A.
  logic          pin_b;        // External pin B.
  pief_src_t     vector_req_out;
  logic          core_irq_out;
  logic          sys_irq_out;
  int            n_fail;       // Mismatches seen.
  int            n_checks;     // Comparisons made.
  // Register, flag bit and enable bit of each source, in vector order.
  int rg[11] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2};
  int fb[11] = '{4, 5, 6, 4, 5, 6, 7, 4, 5, 6, 7};
  int eb[11] = '{1, 2, 3, 0, 1, 2, 3, 0, 1, 2, 3};

  pief_top i_pief_top (.clk_in(clk_in), .nrst_in(nrst_in), .bus_in(bus),
    .rd_data_out(rd_data_out), .ext_pin_a_in(pin_a), .ext_pin_b_in(pin_b),
    .src_pulse_in(pulse), .vector_req_out(vector_req_out),
    .core_irq_out(core_irq_out), .sys_irq_out(sys_irq_out));

  pief_src_model i_pief_src_model (.clk_in(clk_in), .nrst_in(nrst_in), .fire_in(fire),
    .pulse_out(pulse), .pin_a_out(pin_a), .pin_b_out(pin_b));

  // Free-running 50 MHz clock.
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One write cycle; a free edge follows so strobes never collide.
  task automatic bus_wr(input int a, input logic [7:0] d);
    @(posedge clk_in);
    bus.addr  <= 3'(a);
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
  endtask

  // One read cycle; data is taken in the cycle after the strobe.
  task automatic bus_rd(input int a, output logic [7:0] d);
    @(posedge clk_in);
    bus.addr <= 3'(a);
    bus.rd   <= 1'b1;
    @(posedge clk_in);
    bus.rd <= 1'b0;
    #1 d = rd_data_out;
  endtask

  // Reads a register and compares it.
  task automatic rd_chk(input int a, input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    check({8'h00, d}, {8'h00, exp});
  endtask

  // Waits a bounded time for the core request to reach a level.
  task automatic wait_core(input logic lvl);
    for (int k = 0; k < 20 && core_irq_out !== lvl; k++)
      @(posedge clk_in);
    if (core_irq_out !== lvl)
    begin
      n_fail++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, core_irq_out, lvl);
      close_out();
    end
  endtask

  // Raises one source event for a single cycle.
  task automatic fire_src(input int i);
    @(posedge clk_in);
    fire <= pief_src_t'(11'h1 << i);
    @(posedge clk_in);
    fire <= '0;
  endtask

  // Reset values, unmapped offsets and the unimplemented top bit of the first register.
  task automatic t_reset();
    check({13'h0, core_irq_out, sys_irq_out, |vector_req_out}, 16'h0000);
    for (int a = 0; a < 8; a++)
      rd_chk(a, `PIEF_REG_RESET);
    for (int r = 0; r < 3; r++)
    begin
      bus_wr(r, 8'hFF);
      rd_chk(r, r == 0 ? 8'h7F : 8'hFF);
      if (r == 0)
        check(16'(vector_req_out), 16'h0007);
      bus_wr(r, 8'h00);
    end
  endtask

  // Every source: flag position, gating by enable and global enable, software clear.
  task automatic t_sources();
    logic [7:0] d;
    logic [7:0] w;
    int         k;
    for (int i = 0; i < 11; i++)
    begin
      fire_src(i);
      for (k = 0; k < 10; k++)
      begin
        bus_rd(rg[i], d);
        if (d[fb[i]] === 1'b1)
          break;
      end
      check({8'h00, d}, 16'h1 << fb[i]);
      if (k == 10)
        close_out();
      w = 8'(16'h1 << fb[i]) | 8'(16'h1 << eb[i]);
      bus_wr(rg[i], w);
      repeat (3) @(posedge clk_in);
      check({15'h0, core_irq_out}, 16'h0000);
      bus_wr(0, (rg[i] == 0 ? w : 8'h00) | 8'h01);
      wait_core(1'b1);
      check(16'(vector_req_out), 16'h1 << i);
      rd_chk(rg[i], w | (rg[i] == 0 ? 8'h01 : 8'h00));
      bus_wr(rg[i], 8'(16'h1 << fb[i]) | (rg[i] == 0 ? 8'h01 : 8'h00));
      wait_core(1'b0);
      check(16'(vector_req_out), 16'h0000);
      bus_wr(rg[i], 8'h00);
      bus_wr(0, 8'h00);
      rd_chk(rg[i], 8'h00);
    end
  endtask

  // Event status: request and overrun events, masking and write-one clear.
  task automatic t_events();
    bus_wr(`PIEF_ADDR_EVT_STAT, 8'hFF);
    bus_wr(`PIEF_ADDR_EVT_MASK, 8'hFF);
    rd_chk(`PIEF_ADDR_EVT_MASK, 8'hFF);
    bus_wr(`PIEF_ADDR_EVT_MASK, 8'h03);
    bus_wr(`PIEF_ADDR_CTRL_A, 8'h05);
    fire_src(1);
    wait_core(1'b1);
    repeat (2) @(posedge clk_in);
    check({15'h0, sys_irq_out}, 16'h0001);
    fire_src(1);
    repeat (3) @(posedge clk_in);
    rd_chk(`PIEF_ADDR_EVT_STAT, 8'h03);
    bus_wr(`PIEF_ADDR_EVT_MASK, 8'h00);
    repeat (2) @(posedge clk_in);
    check({15'h0, sys_irq_out}, 16'h0000);
    bus_wr(`PIEF_ADDR_EVT_MASK, 8'h03);
    bus_wr(`PIEF_ADDR_EVT_STAT, 8'h03);
    repeat (2) @(posedge clk_in);
    check({15'h0, sys_irq_out}, 16'h0000);
    rd_chk(`PIEF_ADDR_EVT_STAT, 8'h00);
    bus_wr(`PIEF_ADDR_CTRL_A, 8'h00);
  endtask

  // A source pulse and a software clear of its flag meet at one edge; the set must win.
  task automatic t_set_wins(input int i, input int r, input logic [7:0] f);
    @(posedge clk_in);
    fire <= pief_src_t'(11'h1 << i);
    @(posedge clk_in);
    fire      <= '0;
    bus.addr  <= 3'(r);
    bus.wdata <= 8'h00;
    bus.wr    <= 1'b1;
    @(posedge clk_in);
    bus.wr <= 1'b0;
    rd_chk(r, f);
    bus_wr(r, 8'h00);
    rd_chk(r, 8'h00);
  endtask

  // Main sequence: reset for ten cycles, then each scenario in turn.
  initial
  begin
    n_fail   = 0;
    n_checks = 0;
    nrst_in  = 1'b0;
    bus      = '0;
    fire     = '0;
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    #1;
    t_reset();
    t_sources();
    t_events();
    t_set_wins(1, `PIEF_ADDR_CTRL_A, 8'h20);
    t_set_wins(6, `PIEF_ADDR_CTRL_B, 8'h80);
    close_out();
  end
endmodule
